// >>> common/hvd_pkg.sv
`default_nettype none
package hvd_pkg;
  localparam int HVD_WORD_W = 24;
  localparam int HVD_OUT_N = 21;
  localparam int HVD_SEL_BIT = 0;
  localparam int HVD_OUT_LSB = 1;
  localparam int HVD_CUR_LIM_DIS_BIT = 8;
  localparam int HVD_SYNC_BIT = 7;
  localparam int HVD_SOFT_START_DIS_BIT = 6;
  localparam int HVD_CUR_LIM_LSB = 4;
  localparam int HVD_VSEL_LSB = 1;
  localparam logic [23:0] HVD_CFG_MASK = 24'h0001fe;
  localparam logic [23:0] HVD_DATA_MASK = 24'h3ffffe;
  localparam logic [23:0] HVD_WORD_RESET = 24'h000000;
  localparam logic [2:0] HVD_VSEL_SHUTDOWN = 3'h0;
endpackage
`default_nettype wire

// >>> common/hvd_xfer_if.sv
`default_nettype none
// word handed from the link domain to the core domain
interface hvd_xfer_if;
  logic [23:0] word;
  logic toggle;
  modport src (output word, output toggle);
  modport dst (input word, input toggle);
endinterface
`default_nettype wire

// >>> design/hvd_shift.sv
`default_nettype none
module hvd_shift
  import hvd_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  hvd_xfer_if.src xfer
);
  logic [23:0] shift_r;
  logic strobe_q_r;
  logic [23:0] word_r;
  logic toggle_r;

  // ----------------------------------------
  // shift on falling serial clock, msb first
  // ----------------------------------------
  // latch strobe low clears and enables; high freezes the register.
  // the strobe is sampled on the serial clock, so the host keeps the
  // clock running one edge past the strobe rise.
  always_ff @(negedge link_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      shift_r <= HVD_WORD_RESET;
    else if (!latch_strobe_in && strobe_q_r)
      shift_r <= {23'h0, serial_data_in};
    else if (!latch_strobe_in)
      shift_r <= {shift_r[22:0], serial_data_in};
  end

  always_ff @(negedge link_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      strobe_q_r <= 1'b1;
    else
      strobe_q_r <= latch_strobe_in;
  end

  // ----------------------------------------
  // capture and hand over on strobe rise
  // ----------------------------------------
  // strobe rise capture
  always_ff @(negedge link_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      word_r <= HVD_WORD_RESET;
      toggle_r <= 1'b0;
    end
    else if (latch_strobe_in && !strobe_q_r)
    begin
      word_r <= shift_r;
      toggle_r <= ~toggle_r;
    end
  end

  assign xfer.word = word_r;
  assign xfer.toggle = toggle_r;
endmodule
`default_nettype wire

// >>> design/hvd_word_decode.sv
`default_nettype none
module hvd_word_decode
  import hvd_pkg::*;
#(
  parameter int OUT_N = HVD_OUT_N
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  input wire logic boost_pulse_input_in,
  input wire logic boost_target_reached_in,
  output logic [OUT_N-1:0] hv_outputs_out,
  output logic hv_outputs_hiz_out,
  output logic boost_switch_on_out,
  output logic current_limit_disable_out,
  output logic boost_sync_enable_out,
  output logic soft_start_disable_out,
  output logic [1:0] current_limit_select_out,
  output logic [2:0] boost_voltage_select_out,
  output logic [23:0] data_word_out,
  output logic [23:0] boost_configuration_word_out
);
  hvd_xfer_if xfer ();

  hvd_shift u_shift (
    .link_clk_in(link_clk_in),
    .reset_n_in(reset_n_in),
    .serial_data_in(serial_data_in),
    .latch_strobe_in(latch_strobe_in),
    .xfer(xfer)
  );

  // ----------------------------------------
  // crossing
  // ----------------------------------------
  // word is stable for many core cycles after each toggle, so a
  // synchronised toggle qualifies it safely.
  logic [2:0] tog_sync_r;
  logic new_word;
  logic [23:0] data_word_r;
  logic [23:0] cfg_word_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      tog_sync_r <= 3'h0;
    else
      tog_sync_r <= {tog_sync_r[1:0], xfer.toggle};
  end

  assign new_word = tog_sync_r[2] ^ tog_sync_r[1];

  // ----------------------------------------
  // word routing
  // ----------------------------------------
  // lsb one to data
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      data_word_r <= HVD_WORD_RESET;
    else if (new_word && xfer.word[HVD_SEL_BIT])
      data_word_r <= (xfer.word & HVD_DATA_MASK) | 24'h000001;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cfg_word_r <= HVD_WORD_RESET;
    else if (new_word && !xfer.word[HVD_SEL_BIT])
      cfg_word_r <= xfer.word & HVD_CFG_MASK;
  end

  assign data_word_out = data_word_r;
  assign boost_configuration_word_out = cfg_word_r;

  assign current_limit_disable_out = cfg_word_r[HVD_CUR_LIM_DIS_BIT];
  assign boost_sync_enable_out = cfg_word_r[HVD_SYNC_BIT];
  assign soft_start_disable_out = cfg_word_r[HVD_SOFT_START_DIS_BIT];
  assign current_limit_select_out = cfg_word_r[HVD_CUR_LIM_LSB +: 2];
  assign boost_voltage_select_out = cfg_word_r[HVD_VSEL_LSB +: 3];

  // ----------------------------------------
  // output latches
  // ----------------------------------------
  // per-latch drive
  genvar gi;
  generate
    for (gi = 0; gi < OUT_N; gi++)
    begin : g_out
      assign hv_outputs_out[gi] = data_word_r[HVD_OUT_LSB + gi];
    end
  endgenerate

  logic shutdown;
  logic hiz_r;

  assign shutdown = (boost_voltage_select_out == HVD_VSEL_SHUTDOWN);

  // the register clears to the shutdown code, so outputs start high-z
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      hiz_r <= 1'b1;
    else
      hiz_r <= shutdown;
  end

  assign hv_outputs_hiz_out = hiz_r;

  // ----------------------------------------
  // boost switch-off
  // ----------------------------------------
  // both levels are asynchronous to clk_in; the pulse input takes a
  // third stage so that its rising edge is seen exactly once
  typedef enum logic [1:0]
  {
    BOOST_IDLE,
    BOOST_CHARGE,
    BOOST_HOLD
  } hvd_boost_state_type;

  logic [2:0] pulse_sync_r;
  logic [1:0] reach_sync_r;
  logic pulse_rise;
  logic at_target;
  hvd_boost_state_type boost_state_r;
  hvd_boost_state_type boost_state_nxt;
  logic boost_on_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pulse_sync_r <= 3'h0;
    else
      pulse_sync_r <= {pulse_sync_r[1:0], boost_pulse_input_in};
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reach_sync_r <= 2'h0;
    else
      reach_sync_r <= {reach_sync_r[0], boost_target_reached_in};
  end

  assign pulse_rise = pulse_sync_r[1] && !pulse_sync_r[2];
  assign at_target = reach_sync_r[1];

  // hold keeps the switch on at target until the pulse edge; shutdown
  // always wins so the switch never runs with the outputs high-z
  always_comb
  begin
    boost_state_nxt = boost_state_r;
    case (boost_state_r)
      BOOST_IDLE:
      begin
        // pulse edge turns on below target
        if (!shutdown && !at_target && pulse_rise)
          boost_state_nxt = BOOST_CHARGE;
      end
      BOOST_CHARGE:
      begin
        if (shutdown)
          boost_state_nxt = BOOST_IDLE;
        else if (at_target && !boost_sync_enable_out)
          boost_state_nxt = BOOST_IDLE;
        else if (at_target && pulse_rise)
          boost_state_nxt = BOOST_IDLE;
        else if (at_target)
          boost_state_nxt = BOOST_HOLD;
      end
      BOOST_HOLD:
      begin
        if (shutdown)
          boost_state_nxt = BOOST_IDLE;
        else if (at_target && !boost_sync_enable_out)
          boost_state_nxt = BOOST_IDLE;
        else if (at_target && pulse_rise)
          boost_state_nxt = BOOST_IDLE;
        else if (!at_target)
          boost_state_nxt = BOOST_CHARGE;
      end
      default:
      begin
        boost_state_nxt = BOOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      boost_state_r <= BOOST_IDLE;
    else
      boost_state_r <= boost_state_nxt;
  end

  // the switch level comes from a flop so it cannot glitch
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      boost_on_r <= 1'b0;
    else
      boost_on_r <= (boost_state_nxt != BOOST_IDLE);
  end

  assign boost_switch_on_out = boost_on_r;
endmodule
`default_nettype wire

// >>> tb/hvd_host.sv
`default_nettype none
module hvd_host
(
  output var logic link_clk_out,
  output var logic serial_data_out,
  output var logic latch_strobe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {link_clk_out, serial_data_out, latch_strobe_out} = 3'h1;
  task automatic send(input logic [23:0] w);
    latch_strobe_out = 1'b0;
    #5;
    for (int i = 23; i >= 0; i--)
    begin
      link_clk_out = 1'b1;
      serial_data_out = w[i];
      #16 link_clk_out = 1'b0;
      #16;
    end
    // inverted once released, so a stale bit cannot pass
    serial_data_out = ~w[0];
    latch_strobe_out = 1'b1;
    #16 link_clk_out = 1'b1;
    #16 link_clk_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/hvd_word_decode_chk.sv
`default_nettype none
module hvd_word_decode_chk
  import hvd_pkg::*;
#(
  parameter int OUT_N = HVD_OUT_N
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic latch_strobe_in,
  input wire logic boost_pulse_input_in,
  input wire logic boost_target_reached_in,
  input wire logic [OUT_N-1:0] hv_outputs_out,
  input wire logic boost_switch_on_out,
  input wire logic boost_sync_enable_out,
  input wire logic [2:0] boost_voltage_select_out,
  input wire logic [23:0] data_word_out,
  input wire logic [23:0] boost_configuration_word_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  latch_map_a: assert property (
    hv_outputs_out == data_word_out[OUT_N:1]) else $error("latch map");
  data_pad_a: assert property (
    data_word_out[23:22] == 2'h0) else $error("data pad");
  data_sel_a: assert property (
    |data_word_out |-> data_word_out[0]) else $error("data select");
  cfg_pad_a: assert property (
    (boost_configuration_word_out & ~HVD_CFG_MASK) == 24'h0)
    else $error("cfg pad");
  strobe_load_a: assert property (
    $changed(data_word_out) || $changed(boost_configuration_word_out)
    |-> latch_strobe_in) else $error("load without strobe");
  shutdown_off_a: assert property (
    (boost_voltage_select_out == 3'h0) [*2] |-> !boost_switch_on_out)
    else $error("on in shutdown");
  async_off_a: assert property (
    (!boost_sync_enable_out && boost_target_reached_in) [*5]
    |-> !boost_switch_on_out) else $error("late off");
  sync_off_a: assert property (
    $fell(boost_switch_on_out) && boost_sync_enable_out
    && $past(boost_sync_enable_out) && boost_voltage_select_out != 3'h0
    |-> $past(boost_pulse_input_in, 2) || $past(boost_pulse_input_in, 3))
    else $error("off without pulse");
endmodule
bind hvd_word_decode hvd_word_decode_chk #(.OUT_N(OUT_N)) chk (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .latch_strobe_in(latch_strobe_in),
  .boost_pulse_input_in(boost_pulse_input_in),
  .boost_target_reached_in(boost_target_reached_in),
  .hv_outputs_out(hv_outputs_out),
  .boost_switch_on_out(boost_switch_on_out),
  .boost_sync_enable_out(boost_sync_enable_out),
  .boost_voltage_select_out(boost_voltage_select_out),
  .data_word_out(data_word_out),
  .boost_configuration_word_out(boost_configuration_word_out)
);
`default_nettype wire

// >>> tb/hvd_word_decode_bench.sv
`default_nettype none
module hvd_word_decode_bench
  import hvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_n = 1'b0;
  logic pulse = 1'b0;
  logic target = 1'b0;
  wire logic lclk, sd, strobe;
  logic [20:0] hv;
  logic hiz, sw, cld, bse, ssd;
  logic [1:0] cls;
  logic [2:0] bvs;
  logic [23:0] dw, cw, ed = 24'h0, ec = 24'h0;
  int failures = 0, samples_checked = 0, seed = 32'h9ea5, cycles = 0;
  hvd_host host (.link_clk_out(lclk), .serial_data_out(sd),
    .latch_strobe_out(strobe));
  hvd_word_decode dut (.clk_in(clk_in), .reset_n_in(rst_n),
    .link_clk_in(lclk), .serial_data_in(sd), .latch_strobe_in(strobe),
    .boost_pulse_input_in(pulse), .boost_target_reached_in(target),
    .hv_outputs_out(hv), .hv_outputs_hiz_out(hiz),
    .boost_switch_on_out(sw), .current_limit_disable_out(cld),
    .boost_sync_enable_out(bse), .soft_start_disable_out(ssd),
    .current_limit_select_out(cls), .boost_voltage_select_out(bvs),
    .data_word_out(dw), .boost_configuration_word_out(cw));
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (++cycles == 4000)
    begin
      failures++;
      wrap_up();
    end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [23:0] data_of(input logic [23:0] v);
    return (v & HVD_DATA_MASK) | 24'h1;
  endfunction
  task automatic put(input logic [23:0] v);
    host.send(v);
    repeat (8) @(negedge clk_in);
    ed = v[0] ? data_of(v) : ed;
    ec = v[0] ? ec : v & HVD_CFG_MASK;
    check(dw, ed); // data word
    check(cw, ec); // config word
    check(24'({cld, bse, ssd, cls, bvs}), 24'(ec[8:1])); // fields
    check(24'(hv), 24'(ed[21:1])); // latch pattern
  endtask
  task automatic boost(input logic s);
    put({16'h0, s, 3'h0, 3'h7, 1'b0});
    pulse = 1'b1;
    repeat (8) @(negedge clk_in);
    pulse = 1'b0;
    check(24'(sw), 24'h1); // switch on below target
    target = 1'b1;
    repeat (8) @(negedge clk_in);
    check(24'(sw), 24'(s)); // held only when synced
    pulse = 1'b1;
    repeat (8) @(negedge clk_in);
    check(24'(sw), 24'h0); // off after pulse rise
    pulse = 1'b0;
    target = 1'b0;
  endtask
  initial
  begin
    repeat (8) @(negedge clk_in);
    rst_n = 1'b1;
    check(dw, 24'h0); // cleared at reset
    check(cw, 24'h0); // cleared at reset
    check(24'(hiz), 24'h1); // shutdown code after reset
    put(24'hffffff);
    put(24'hfffffe);
    put(24'h000001);
    put(24'h000000);
    repeat (30) put(24'($random(seed)));
    $display("test words done");
    for (int v = 0; v < 8; v++)
    begin
      put({20'h0, 3'(v), 1'b0});
      check(24'(hiz), 24'(v == 0)); // high-z only in shutdown
    end
    boost(1'b0);
    boost(1'b1);
    $display("test boost done");
    wrap_up();
  end
endmodule
`default_nettype wire
